// File: logic/acr_consts.svh
// Purpose: Constants of the analogue channel trigger readout block
// Assumes: 20 MHz system clock, APB byte addresses
// Notes: Times are kept in ns, cycle counts derive from them
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// ==========================================================
// Timing
`define ACR_CLK_NS 50
`define ACR_SCK_HALF_NS 500
`define ACR_SCK_HALF_CYC ((`ACR_SCK_HALF_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_AGE_TICK_NS 1000000
`define ACR_AGE_TICK_CYC (`ACR_AGE_TICK_NS / `ACR_CLK_NS)

// ==========================================================
// Register map: page is paddr[7:4], word is paddr[3:2]
`define ACR_PG_MAIN 4'h0
`define ACR_PG_CH 4'h1
`define ACR_PG_REC 4'h2
`define ACR_W_CTRL 2'h0
`define ACR_W_OUTB 2'h1
`define ACR_W_AGE_LIM 2'h2
`define ACR_W_STAT 2'h3

// ==========================================================
// Fields and reset values
`define ACR_F_LO 14:0
`define ACR_F_HI 30:16
`define ACR_B_CUR 31
`define ACR_RST_CFG 32'h0000_0000
`define ACR_RST_LIM 16'h0000
`define ACR_LEN_TRIG 5'h01
`define ACR_LEN_READ 5'h10

// ==========================================================
// Frame: one output byte, then sixteen reading bytes
`define ACR_N_CH 4
`define ACR_N_RX 16
`define ACR_LAST_IDX 5'h10

`endif

// File: logic/acr_pkg.sv
// Purpose: Types of the analogue channel trigger readout block
// Assumes: Constants come from acr_consts.svh
// Notes: Control struct matches the CTRL register bit order
package acr_pkg;

    typedef enum logic {ACR_MODE_TRIG, ACR_MODE_READ} acr_mode_t;

    typedef struct packed {
        logic run;
        logic suppress;
        logic act_low;
        acr_mode_t mode;
    } acr_ctrl_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } acr_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } acr_apb_rsp_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic mosi;
    } acr_spi_t;

endpackage : acr_pkg

// File: logic/acr_spi_byte.sv
// Purpose: SPI mode 0 byte shifter, MSB first
// Assumes: Caller holds chip select around the byte
// Notes: One byte takes sixteen half periods of the serial clock
`timescale 1ns/1ps
`include "acr_consts.svh"

module acr_spi_byte (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_start,
    input wire logic [7:0] i_tx,
    input wire logic i_miso,
    output logic o_sck,
    output logic o_mosi,
    output logic o_done,
    output logic o_busy,
    output logic [7:0] o_rx
);

    logic [3:0] div_r, div_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt, rx_r, rx_nxt;
    logic sck_r, sck_nxt, mosi_r, mosi_nxt;
    logic done_r, done_nxt, busy_r, busy_nxt;
    logic half;

    always_comb
    begin
        half = busy_r && (div_r == 4'(`ACR_SCK_HALF_CYC - 1));
        div_nxt = busy_r ? (half ? 4'h0 : div_r + 4'h1) : 4'h0;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        rx_nxt = rx_r;
        sck_nxt = sck_r;
        mosi_nxt = mosi_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (i_start && !busy_r)
        begin
            busy_nxt = 1'b1;
            bit_nxt = 3'h0;
            sh_nxt = i_tx;
            mosi_nxt = i_tx[7];
            sck_nxt = 1'b0;
        end
        else if (half)
        begin
            if (!sck_r)
            begin
                sck_nxt = 1'b1;
                rx_nxt = {rx_r[6:0], i_miso};
            end
            else
            begin
                sck_nxt = 1'b0;
                if (bit_r == 3'h7)
                begin
                    busy_nxt = 1'b0;
                    done_nxt = 1'b1;
                end
                else
                begin
                    bit_nxt = bit_r + 3'h1;
                    sh_nxt = {sh_r[6:0], 1'b0};
                    mosi_nxt = sh_r[6];
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            div_r <= 4'h0;
            bit_r <= 3'h0;
            sh_r <= 8'h00;
            rx_r <= 8'h00;
            sck_r <= 1'b0;
            mosi_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            rx_r <= rx_nxt;
            sck_r <= sck_nxt;
            mosi_r <= mosi_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_sck = sck_r;
    assign o_mosi = mosi_r;
    assign o_done = done_r;
    assign o_busy = busy_r;
    assign o_rx = rx_r;

    a_byte_done_bound: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_start && !busy_r) |-> ##[150:170] done_r)
        else $error("spi byte did not finish in time");

endmodule : acr_spi_byte

// File: logic/acr_top.sv
// Purpose: Four channel analogue readout with trigger and readings modes
// Assumes: APB register access, SPI link to the expansion board as master
// Notes: One frame per age tick while running, none while stale with suppress set; results refresh in one cycle
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "acr_consts.svh"

// Functional notes
// - Inputs mode register selects trigger or readings processing
// - Trigger mode yields one byte covering all four channels
// - Flag set when level is below low or above high point
// - Byte bits pair per channel: low then high, channel 1 at bits 0 and 1
// - Active low option inverts every trigger flag
// - Readings mode yields a sixteen byte record
// - Each reading: 15 bit value MSB first, bit 16 flags current
// - Record order: per channel voltage then current, channels 1 to 4
// - Each channel holds a type plus high and low trigger levels
// - Trigger levels have no effect in readings mode
// - Stale source data may suppress all transmission
// - One output byte is forwarded to the board
// - Board is reached only over SPI with this block as master
module acr_top #(
    parameter int AGE_TICK_CYC = `ACR_AGE_TICK_CYC
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire acr_pkg::acr_apb_req_t i_apb,
    input wire logic i_miso,
    output acr_pkg::acr_apb_rsp_t o_apb,
    output acr_pkg::acr_spi_t o_spi,
    output logic [127:0] o_rec,
    output logic [4:0] o_rec_len,
    output logic o_rec_upd,
    output logic o_rec_valid
);

    typedef enum logic [2:0] {ACR_ST_IDLE, ACR_ST_BYTE, ACR_ST_WAIT, ACR_ST_PROC} acr_st_t;

    // ==========================================================
    // Registers and APB slave
    acr_pkg::acr_ctrl_t ctrl_r, ctrl_nxt;
    logic [7:0] outb_r, outb_nxt;
    logic [15:0] lim_r, lim_nxt, age_r, age_nxt;
    logic [14:0] tick_r, tick_nxt;
    logic [31:0] cfg_r [`ACR_N_CH];
    logic [31:0] cfg_nxt [`ACR_N_CH];
    logic stale_r, stale_nxt, tick_pls_r, tick_pls_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt, rdata;
    logic hit, acc, wr;
    logic [3:0] page;
    logic [1:0] word;

    // Acquisition state
    acr_st_t st_r, st_nxt;
    logic [4:0] idx_r, idx_nxt, len_r, len_nxt;
    logic [7:0] raw_r [`ACR_N_RX];
    logic [7:0] raw_nxt [`ACR_N_RX];
    logic [7:0] tx_r, tx_nxt;
    logic [127:0] rec_r, rec_nxt;
    logic cs_n_r, cs_n_nxt, start_r, start_nxt;
    logic upd_r, upd_nxt, valid_r, valid_nxt;
    logic spi_done, spi_busy, spi_sck, spi_mosi;
    logic [7:0] spi_rx;
    logic [7:0] trig_w;
    logic [127:0] read_w;

    assign page = i_apb.paddr[7:4];
    assign word = i_apb.paddr[3:2];
    assign acc = i_apb.psel && i_apb.penable;
    assign wr = acc && pready_r && i_apb.pwrite && hit;

    always_comb
    begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (page)
            `ACR_PG_MAIN:
            begin
                case (word)
                    `ACR_W_CTRL: rdata = {28'h000_0000, ctrl_r};
                    `ACR_W_OUTB: rdata = {24'h00_0000, outb_r};
                    `ACR_W_AGE_LIM: rdata = {16'h0000, lim_r};
                    default: rdata = {29'h0000_0000, st_r != ACR_ST_IDLE, stale_r, valid_r};
                endcase
            end
            `ACR_PG_CH: rdata = cfg_r[word];
            `ACR_PG_REC: rdata = rec_r[32*word +: 32];
            default: hit = 1'b0;
        endcase
    end

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        outb_nxt = outb_r;
        lim_nxt = lim_r;
        cfg_nxt = cfg_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        tick_pls_nxt = (tick_r == 15'(AGE_TICK_CYC - 1));
        tick_nxt = tick_pls_nxt ? 15'h0000 : tick_r + 15'h0001;
        age_nxt = (tick_pls_r && age_r != 16'hFFFF) ? age_r + 16'h0001 : age_r;
        if (acc && !pready_r)
        begin
            pready_nxt = 1'b1;
            pslverr_nxt = !hit;
            prdata_nxt = rdata;
        end
        if (wr && page == `ACR_PG_MAIN)
        begin
            case (word)
                `ACR_W_CTRL: ctrl_nxt = acr_pkg::acr_ctrl_t'(i_apb.pwdata[3:0]);
                `ACR_W_OUTB:
                begin
                    outb_nxt = i_apb.pwdata[7:0];
                    age_nxt = 16'h0000;
                end
                `ACR_W_AGE_LIM: lim_nxt = i_apb.pwdata[15:0];
                default: ;
            endcase
        end
        if (wr && page == `ACR_PG_CH)
        begin
            cfg_nxt[word] = i_apb.pwdata;
        end
        stale_nxt = (lim_r != 16'h0000) && (age_nxt >= lim_r);
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctrl_r <= '0;
            outb_r <= 8'h00;
            lim_r <= `ACR_RST_LIM;
            age_r <= 16'h0000;
            tick_r <= 15'h0000;
            tick_pls_r <= 1'b0;
            stale_r <= 1'b0;
            cfg_r <= '{default: `ACR_RST_CFG};
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            outb_r <= outb_nxt;
            lim_r <= lim_nxt;
            age_r <= age_nxt;
            tick_r <= tick_nxt;
            tick_pls_r <= tick_pls_nxt;
            stale_r <= stale_nxt;
            cfg_r <= cfg_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ==========================================================
    // Per-channel evaluation
    genvar g;
    generate
        for (g = 0; g < `ACR_N_CH; g++)
        begin : g_ch
            logic [14:0] volt, curr, lvl;
            assign volt = {raw_r[4*g][6:0], raw_r[4*g+1]};
            assign curr = {raw_r[4*g+2][6:0], raw_r[4*g+3]};
            assign lvl = cfg_r[g][`ACR_B_CUR] ? curr : volt;
            assign trig_w[2*g] = (lvl < cfg_r[g][`ACR_F_LO]) ^ ctrl_r.act_low;
            assign trig_w[2*g+1] = (lvl > cfg_r[g][`ACR_F_HI]) ^ ctrl_r.act_low;
            assign read_w[32*g +: 16] = {1'b0, volt};
            assign read_w[32*g+16 +: 16] = {1'b1, curr};
        end
    endgenerate

    // ==========================================================
    // Acquisition sequencer
    always_comb
    begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        raw_nxt = raw_r;
        tx_nxt = tx_r;
        rec_nxt = rec_r;
        len_nxt = len_r;
        cs_n_nxt = cs_n_r;
        start_nxt = 1'b0;
        upd_nxt = 1'b0;
        valid_nxt = (stale_r && ctrl_r.suppress) ? 1'b0 : valid_r;
        case (st_r)
            ACR_ST_IDLE:
            begin
                if (ctrl_r.run && tick_pls_r && !(stale_r && ctrl_r.suppress))
                begin
                    cs_n_nxt = 1'b0;
                    idx_nxt = 5'h00;
                    st_nxt = ACR_ST_BYTE;
                end
            end
            ACR_ST_BYTE:
            begin
                start_nxt = !spi_busy;
                tx_nxt = (idx_r == 5'h00) ? outb_r : 8'h00;
                st_nxt = spi_busy ? ACR_ST_BYTE : ACR_ST_WAIT;
            end
            ACR_ST_WAIT:
            begin
                if (spi_done)
                begin
                    if (idx_r != 5'h00)
                    begin
                        raw_nxt[4'(idx_r - 5'h01)] = spi_rx;
                    end
                    if (idx_r == `ACR_LAST_IDX)
                    begin
                        cs_n_nxt = 1'b1;
                        st_nxt = ACR_ST_PROC;
                    end
                    else
                    begin
                        idx_nxt = idx_r + 5'h01;
                        st_nxt = ACR_ST_BYTE;
                    end
                end
            end
            ACR_ST_PROC:
            begin
                if (ctrl_r.mode == acr_pkg::ACR_MODE_TRIG)
                begin
                    rec_nxt = {120'h0, trig_w};
                    len_nxt = `ACR_LEN_TRIG;
                end
                else
                begin
                    rec_nxt = read_w;
                    len_nxt = `ACR_LEN_READ;
                end
                upd_nxt = 1'b1;
                valid_nxt = 1'b1;
                st_nxt = ACR_ST_IDLE;
            end
            default: st_nxt = ACR_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_r <= ACR_ST_IDLE;
            idx_r <= 5'h00;
            raw_r <= '{default: 8'h00};
            tx_r <= 8'h00;
            rec_r <= '0;
            len_r <= `ACR_LEN_TRIG;
            cs_n_r <= 1'b1;
            start_r <= 1'b0;
            upd_r <= 1'b0;
            valid_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            raw_r <= raw_nxt;
            tx_r <= tx_nxt;
            rec_r <= rec_nxt;
            len_r <= len_nxt;
            cs_n_r <= cs_n_nxt;
            start_r <= start_nxt;
            upd_r <= upd_nxt;
            valid_r <= valid_nxt;
        end
    end

    acr_spi_byte acr_spi_byte_inst (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_start(start_r),
        .i_tx(tx_r),
        .i_miso(i_miso),
        .o_sck(spi_sck),
        .o_mosi(spi_mosi),
        .o_done(spi_done),
        .o_busy(spi_busy),
        .o_rx(spi_rx)
    );

    assign o_apb = '{pready: pready_r, pslverr: pslverr_r, prdata: prdata_r};
    assign o_spi = '{cs_n: cs_n_r, sck: spi_sck, mosi: spi_mosi};
    assign o_rec = rec_r;
    assign o_rec_len = len_r;
    assign o_rec_upd = upd_r;
    assign o_rec_valid = valid_r;

    // ==========================================================
    // Checks
    a_mode_len: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        upd_r |-> len_r == (($past(ctrl_r.mode) == acr_pkg::ACR_MODE_TRIG) ? `ACR_LEN_TRIG
        : `ACR_LEN_READ))
        else $error("record length does not follow mode");
    a_trig_one_byte: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (upd_r && len_r == `ACR_LEN_TRIG) |-> rec_r[127:8] == 120'h0)
        else $error("trigger result wider than one byte");
    a_low_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_r == ACR_ST_PROC && ctrl_r.mode == acr_pkg::ACR_MODE_TRIG && !ctrl_r.act_low
         && g_ch[0].lvl < cfg_r[0][`ACR_F_LO]) |=> rec_r[0])
        else $error("channel 1 low flag missing");
    a_pair_order: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_r == ACR_ST_PROC && ctrl_r.mode == acr_pkg::ACR_MODE_TRIG)
        |=> rec_r[7] == $past((g_ch[3].lvl > cfg_r[3][`ACR_F_HI]) ^ ctrl_r.act_low))
        else $error("channel 4 high flag not at top bit");
    a_polarity_inv: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_r == ACR_ST_PROC && ctrl_r.mode == acr_pkg::ACR_MODE_TRIG && ctrl_r.act_low
         && g_ch[2].lvl <= cfg_r[2][`ACR_F_HI]) |=> rec_r[5])
        else $error("inactive flag not high in active low");
    a_read_flags: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (upd_r && len_r == `ACR_LEN_READ) |-> (!rec_r[15] && rec_r[31] && rec_r[127]))
        else $error("reading type flag wrong");
    a_read_order: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_r == ACR_ST_PROC && ctrl_r.mode == acr_pkg::ACR_MODE_READ)
        |=> rec_r[110:96] == $past({raw_r[12][6:0], raw_r[13]}))
        else $error("channel 4 voltage misplaced");
    a_stale_silent: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (st_r == ACR_ST_IDLE && stale_r && ctrl_r.suppress) |=> cs_n_r)
        else $error("frame started on stale data");
    a_out_byte: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (start_r && idx_r == 5'h00) |-> tx_r == $past(outb_r))
        else $error("output byte not sent first");
    a_atomic_upd: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $changed(rec_r) |-> upd_r && $past(st_r == ACR_ST_PROC))
        else $error("record changed outside refresh");

endmodule : acr_top

// File: verif/acr_board_model.sv
// Purpose: Behavioural analogue expansion board answering as SPI slave, mode 0
// Assumes: MSB first; byte 0 carries the output byte, bytes 1 to 16 the readings
// Notes: Released data line shows the inverse of its last value
`timescale 1ns/1ps

module acr_board_model (
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic [127:0] i_img,
    output logic o_miso,
    output logic [7:0] o_outb
);
    int n;
    logic [7:0] sh;

    // ==========================================================
    // Serial image lookup
    function automatic logic bit_at(input int k);
        int b;
        b = k / 8;
        if (b == 0 || b > 16)
            return 1'b0;
        return i_img[8 * (b - 1) + 7 - k % 8];
    endfunction : bit_at

    initial
    begin
        n = 0;
        sh = 8'h00;
        o_miso = 1'b0;
        o_outb = 8'h00;
    end

    // ==========================================================
    // Slave shifter
    always @(negedge i_cs_n)
    begin
        n = 0;
        o_miso <= bit_at(0);
    end

    always @(posedge i_cs_n)
        o_miso <= ~o_miso;

    always @(posedge i_sck)
    begin
        if (!i_cs_n)
        begin
            sh = {sh[6:0], i_mosi};
            if (n == 7)
                o_outb <= sh;
            n = n + 1;
        end
    end

    always @(negedge i_sck)
    begin
        if (!i_cs_n)
            o_miso <= bit_at(n);
    end
endmodule : acr_board_model

// File: verif/acr_top_tb_top.sv
// Purpose: Self-checking bench of the analogue readout block over APB
// Assumes: Board model on SPI, shortened age tick
// Notes: Trigger, readings, polarity and stale suppression are exercised
`timescale 1ns/1ps
`include "acr_consts.svh"

module acr_top_tb_top;
    localparam int TICK = 4000;
    logic i_clk;
    logic i_arst_n;
    acr_pkg::acr_apb_req_t i_apb;
    acr_pkg::acr_apb_rsp_t o_apb;
    acr_pkg::acr_spi_t o_spi;
    logic i_miso;
    logic [127:0] o_rec;
    logic [4:0] o_rec_len;
    logic o_rec_upd;
    logic o_rec_valid;
    logic [127:0] img;
    logic [127:0] exp_rec;
    logic [127:0] prev_rec;
    logic [7:0] outb_seen;
    logic [14:0] vals [8];
    logic [31:0] rd;
    logic err;
    int errors;
    int compares;

    acr_top #(.AGE_TICK_CYC(TICK)) acr_top_inst (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_apb(i_apb), .i_miso(i_miso),
        .o_apb(o_apb), .o_spi(o_spi), .o_rec(o_rec), .o_rec_len(o_rec_len),
        .o_rec_upd(o_rec_upd), .o_rec_valid(o_rec_valid)
    );

    acr_board_model acr_board_model_inst (
        .i_cs_n(o_spi.cs_n), .i_sck(o_spi.sck), .i_mosi(o_spi.mosi),
        .i_img(img), .o_miso(i_miso), .o_outb(outb_seen)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [127:0] seen, input logic [127:0] expv);
        compares++;
        if (seen !== expv)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // APB master
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_clk);
        i_apb.penable <= 1'b1;
        do
            @(posedge i_clk);
        while (o_apb.pready !== 1'b1);
        rd = o_apb.prdata;
        err = o_apb.pslverr;
        i_apb.psel <= 1'b0;
        i_apb.penable <= 1'b0;
        @(posedge i_clk);
    endtask : apb

    task automatic wait_upd(input int n);
        int k;
        repeat (n)
        begin
            for (k = 0; k < 3 * TICK && o_rec_upd !== 1'b1; k++)
                @(posedge i_clk);
            check(k < 3 * TICK, 1'b1);
            if (k >= 3 * TICK)
                print_verdict();
            @(posedge i_clk);
        end
    endtask : wait_upd

    // ==========================================================
    // Monitors: no partial output, idle serial clock low
    always @(posedge i_clk)
    begin
        if (i_arst_n && o_rec !== prev_rec && o_rec_upd !== 1'b1)
            check(o_rec, prev_rec);
        if (o_spi.cs_n === 1'b1 && o_spi.sck !== 1'b0)
            check(o_spi.sck, 1'b0);
        prev_rec <= o_rec;
    end

    initial
    begin
        #(90000 * 50);
        errors++;
        print_verdict();
    end

    // ==========================================================
    // Tests
    initial
    begin
        i_apb = '0;
        i_arst_n = 1'b0;
        errors = 0;
        compares = 0;
        prev_rec = '0;
        vals = '{15'h1387, 15'h1b58, 15'h0000, 15'h00c9, 15'h03e8, 15'h7fff, 15'h07d0, 15'h270f};
        for (int r = 0; r < 8; r++)
        begin
            img[16 * r +: 8] = {1'b1, vals[r][14:8]};
            img[16 * r + 8 +: 8] = vals[r][7:0];
            exp_rec[16 * r +: 16] = {r[0], vals[r]};
        end
        repeat (6) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        check(o_rec_len, `ACR_LEN_TRIG);
        check(o_rec_valid, 1'b0);
        apb(1'b0, 8'h00, 32'h0000_0000);
        check(rd, `ACR_RST_CFG);
        apb(1'b0, 8'h30, 32'h0000_0000);
        check({err, rd}, {1'b1, 32'h0000_0000});
        apb(1'b1, 8'h20, 32'hffff_ffff);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        $display("test reset done");

        apb(1'b1, 8'h10, {1'b0, 15'h4e20, 1'b0, 15'h1388});
        apb(1'b1, 8'h14, {1'b1, 15'h00c8, 1'b0, 15'h0064});
        apb(1'b1, 8'h18, {1'b0, 15'h07d0, 1'b0, 15'h03e8});
        apb(1'b1, 8'h1c, {1'b0, 15'h07d0, 1'b0, 15'h03e8});
        apb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, {1'b1, 15'h00c8, 1'b0, 15'h0064});
        apb(1'b1, 8'h04, 32'h0000_00a5);
        apb(1'b1, 8'h00, 32'h0000_0008);
        wait_upd(2);
        check(o_rec, {120'h0, 8'h09});
        check(o_rec_len, `ACR_LEN_TRIG);
        check(outb_seen, 8'ha5);
        check(o_rec_valid, 1'b1);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check(rd, 32'h0000_0009);
        $display("test trigger done");

        apb(1'b1, 8'h00, 32'h0000_000a);
        wait_upd(2);
        check(o_rec, {120'h0, 8'hf6});
        $display("test active low done");

        apb(1'b1, 8'h00, 32'h0000_0009);
        wait_upd(2);
        check(o_rec, exp_rec);
        check(o_rec_len, `ACR_LEN_READ);
        apb(1'b1, 8'h10, {1'b1, 15'h0001, 1'b0, 15'h0000});
        wait_upd(1);
        check(o_rec, exp_rec);
        apb(1'b0, 8'h2c, 32'h0000_0000);
        check(rd, exp_rec[127:96]);
        $display("test readings done");

        apb(1'b1, 8'h04, 32'h0000_003c);
        apb(1'b1, 8'h08, 32'h0000_0002);
        apb(1'b1, 8'h00, 32'h0000_000d);
        repeat (4 * TICK) @(posedge i_clk);
        check(o_rec_valid, 1'b0);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        check(rd[1:0], 2'h2);
        for (int k = 0; k < 3 * TICK; k++)
        begin
            @(posedge i_clk);
            if (o_spi.cs_n !== 1'b1)
                check(o_spi.cs_n, 1'b1);
        end
        apb(1'b1, 8'h04, 32'h0000_005a);
        wait_upd(1);
        check(o_rec_valid, 1'b1);
        check(outb_seen, 8'h5a);
        $display("test stale done");
        print_verdict();
    end
endmodule : acr_top_tb_top
